// >>> shared/smwr_defines.svh
`ifndef SMWR_DEFINES_SVH
`define SMWR_DEFINES_SVH
// ==========================================================
// clock and timing
`define SMWR_CLK_KHZ       40000
`define SMWR_RST_HOLD_US   1000
`define SMWR_RST_HOLD_CYC  ((`SMWR_RST_HOLD_US * `SMWR_CLK_KHZ + 999) / 1000)
`define SMWR_NREQ_TO_MS    150
`define SMWR_NREQ_TO_CYC   (`SMWR_NREQ_TO_MS * `SMWR_CLK_KHZ)
`define SMWR_VDD_LOW_MS    150
`define SMWR_VDD_LOW_CYC   (`SMWR_VDD_LOW_MS * `SMWR_CLK_KHZ + 1)
`define SMWR_WD_WIN_MS     150
`define SMWR_WD_WIN_CYC    (`SMWR_WD_WIN_MS * `SMWR_CLK_KHZ)
`define SMWR_CS_ON_CYC     8'h10
// ==========================================================
// interrupt source register layout
`define SMWR_ISR_W         10
`define SMWR_ISR_WAKE_LSB  0
`define SMWR_ISR_WAKE_W    4
`define SMWR_ISR_FLT_LSB   4
`define SMWR_ISR_FLT_W     6
`define SMWR_ISR_RST       10'h000
// ==========================================================
// reset values and low power counter width
`define SMWR_PIN_INIT      18'h0C004
`define SMWR_LP_CNT_W      16
`endif

// >>> shared/smwr_pkg.sv
`default_nettype none
package smwr_pkg;
  // ==========================================================
  // operating modes
  typedef enum logic [4:0] {
    ST_RESET  = 5'h01,
    ST_NREQ   = 5'h02,
    ST_NORMAL = 5'h04,
    ST_STOP   = 5'h08,
    ST_SLEEP  = 5'h10
  } smwr_mode_e;
  // ==========================================================
  // pin levels from outside the clock domain
  typedef struct packed {
    logic wake_input_one;
    logic wake_input_two;
    logic rst_n;
    logic cs_n;
    logic lin_wake;
    logic pulse_width_input;
    logic watchdog_config_pin_gnd;
    logic watchdog_config_pin_res;
    logic vdd_low;
    logic supply_undervoltage;
    logic supply_overvoltage;
    logic reg_overtemp;
    logic lin_overtemp;
    logic txd_stuck;
    logic rxd_short;
    logic txd_recessive;
    logic hs_overtemp;
    logic ls_overtemp;
  } smwr_pins_s;
  // ==========================================================
  // host configuration
  typedef struct packed {
    logic [1:0]  wake_input_enable;
    logic [1:0]  mux_select;
    logic        cyclic;
    logic        forced;
    logic [15:0] period;
  } smwr_wake_cfg_s;
  typedef struct packed {
    logic       high_side_switch;
    logic [1:0] low_side_switches;
    logic       pwm_gate;
  } smwr_sw_cfg_s;
endpackage
`default_nettype wire

// >>> logic/smwr_sync.sv
`timescale 1ns/10ps
`default_nettype none
module smwr_sync #(
  parameter int         W    = 18,
  parameter logic [W-1:0] INIT = '0
)(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // raw and filtered levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] chg_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] agree;
  logic [W-1:0] level_nxt;

  if (W < 1)
  begin
    $error("sync width must be positive");
  end

  assign agree     = ~(s2_r ^ s3_r);
  assign level_nxt = (agree & s2_r) | (~agree & level_o);

  // ==========================================================
  // three stage chain, change taken when stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s1_r    <= INIT;
      s2_r    <= INIT;
      s3_r    <= INIT;
      level_o <= INIT;
      chg_o   <= '0;
    end
    else
    begin
      s1_r    <= async_i;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_o <= level_nxt;
      chg_o   <= level_nxt ^ level_o;
    end
  end
endmodule
`default_nettype wire

// >>> logic/smwr_timer.sv
`timescale 1ns/10ps
`default_nettype none
module smwr_timer #(
  parameter int CW = 23
)(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // control
  input  wire logic          restart_i,
  input  wire logic          run_i,
  input  wire logic [CW-1:0] limit_i,
  // status
  output logic               done_o,
  output logic               half_o
);
  logic [CW-1:0] cnt_r;

  if (CW < 2)
  begin
    $error("timer width too small");
  end

  // ==========================================================
  // saturating up counter
  always_ff @(posedge clk_i)
  begin
    if (reset_i || restart_i)
      cnt_r <= '0;
    else if (run_i && (cnt_r < limit_i))
      cnt_r <= cnt_r + 1'b1;
  end

  assign done_o = (cnt_r >= limit_i);
  assign half_o = (cnt_r >= (limit_i >> 1));
endmodule
`default_nettype wire

// >>> logic/smwr_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "smwr_defines.svh"
module smwr_mode_ctrl
  import smwr_pkg::*;
#(
  parameter int RST_HOLD_CYC = `SMWR_RST_HOLD_CYC,
  parameter int NREQ_TO_CYC  = `SMWR_NREQ_TO_CYC,
  parameter int VDD_LOW_CYC  = `SMWR_VDD_LOW_CYC,
  parameter int WD_WIN_CYC   = `SMWR_WD_WIN_CYC,
  parameter int CW           = 23
)(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // pins and analog comparators
  input  wire smwr_pins_s            pins_i,
  // host commands
  input  wire logic                  cmd_sleep_i,
  input  wire logic                  cmd_stop_i,
  input  wire logic                  cmd_normal_i,
  input  wire logic                  timing_control_register_write_i,
  input  wire logic                  wd_trigger_i,
  input  wire logic                  isr_read_i,
  // host configuration
  input  wire logic                  lin_receive_only_bit_i,
  input  wire logic [5:0]            irq_mask_i,
  input  wire smwr_wake_cfg_s        wake_cfg_i,
  input  wire smwr_sw_cfg_s          sw_cfg_i,
  // mode, reset line and interrupt line
  output smwr_mode_e                 mode_o,
  output logic                       rst_o,
  output logic                       rst_oe_o,
  output logic                       irq_n_o,
  // gated functions
  output logic                       vdd_reg_en_o,
  output logic                       high_side_switch_o,
  output logic [1:0]                 low_side_switches_o,
  output logic                       mux_en_o,
  output logic                       lin_drv_en_o,
  output logic                       lin_rx_only_o,
  output logic                       lp_osc_en_o,
  output logic                       wd_active_o,
  // status
  output logic [`SMWR_ISR_W-1:0]     isr_o,
  output logic [1:0]                 wake_status_o,
  output logic                       battery_fail_flag_o
);
  // ==========================================================
  // declarations
  smwr_pins_s            pin_s;
  smwr_pins_s            pin_chg;
  smwr_mode_e            st_r;
  smwr_mode_e            st_nxt;
  smwr_mode_e            go_up;
  logic                  in_reset, in_nr, in_norm, in_stop, in_sleep, in_lp, active;
  logic                  ext_hold_r, ext_nxt, ext_rst;
  logic                  rst_drive_r, drv_nxt;
  logic [3:0]            drv_hist_r;
  logic                  wd_gnd_r, wd_res_r, timing_control_register_r;
  logic                  hold_done, mode_done, mode_half, vdd_done;
  logic [CW-1:0]         mode_lim;
  logic                  wd_fail, vdd_back;
  logic                  cyc, forced_en, lp_run, tick, pwm_ok;
  logic [`SMWR_LP_CNT_W-1:0] lp_cnt_r;
  logic [7:0]            on_cnt_r;
  logic [1:0]            lx_lvl, lx_chg, lx_ok, cs_chg, lx_wk, samp_r, mux_block_r;
  logic                  samp_vld_r;
  logic                  lin_wk, forced_wk, cs_wk, flag_wake;
  logic [5:0]            flt_lvl, flt_prev_r, flt_evt;
  logic [`SMWR_ISR_W-1:0] isr_r, isr_set;
  logic                  irq_r, irq_set, irq_block, lin_lock_r, bat_r;

  if (RST_HOLD_CYC < 1 || NREQ_TO_CYC < 2 || VDD_LOW_CYC < 1 || WD_WIN_CYC < 2 ||
      NREQ_TO_CYC >= 2**CW || VDD_LOW_CYC >= 2**CW || WD_WIN_CYC >= 2**CW ||
      RST_HOLD_CYC >= 2**CW)
  begin
    $error("timer counts do not fit the counter width");
  end

  // ==========================================================
  // pin synchronisers
  smwr_sync #(
    .W    ($bits(smwr_pins_s)),
    .INIT (`SMWR_PIN_INIT)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (pins_i),
    .level_o (pin_s),
    .chg_o   (pin_chg)
  );

  assign in_reset = (st_r == ST_RESET);
  assign in_nr    = (st_r == ST_NREQ);
  assign in_norm  = (st_r == ST_NORMAL);
  assign in_stop  = (st_r == ST_STOP);
  assign in_sleep = (st_r == ST_SLEEP);
  assign in_lp    = in_stop || in_sleep;
  assign active   = in_nr || in_norm;

  // ==========================================================
  // timers
  smwr_timer #(.CW (CW)) u_hold (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .restart_i (!in_reset || ext_hold_r || (pin_s.vdd_low && pin_s.supply_undervoltage)),
    .run_i     (in_reset),
    .limit_i   (CW'(RST_HOLD_CYC)),
    .done_o    (hold_done),
    .half_o    ()
  );

  assign mode_lim = in_nr ? CW'(NREQ_TO_CYC) : CW'(WD_WIN_CYC);

  smwr_timer #(.CW (CW)) u_mode (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .restart_i ((st_nxt != st_r) || (in_norm && wd_trigger_i && mode_half)),
    .run_i     (in_nr || (in_norm && wd_res_r)),
    .limit_i   (mode_lim),
    .done_o    (mode_done),
    .half_o    (mode_half)
  );

  smwr_timer #(.CW (CW)) u_vdd (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .restart_i (!in_norm || !pin_s.vdd_low),
    .run_i     (in_norm),
    .limit_i   (CW'(VDD_LOW_CYC)),
    .done_o    (vdd_done),
    .half_o    ()
  );

  // ==========================================================
  // watchdog and reset conditions
  assign wd_fail  = in_norm && wd_res_r && ((wd_trigger_i && !mode_half) || mode_done);
  assign vdd_back = pin_chg.vdd_low && !pin_s.vdd_low;
  assign ext_rst  = !pin_s.rst_n && !rst_drive_r && (drv_hist_r == 4'h0);
  assign go_up    = wd_gnd_r ? ST_NORMAL : ST_NREQ;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wd_gnd_r <= 1'b0;
      wd_res_r <= 1'b0;
    end
    else if (in_reset)
    begin
      wd_gnd_r <= pin_s.watchdog_config_pin_gnd;
      wd_res_r <= pin_s.watchdog_config_pin_res;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || !in_nr)
      timing_control_register_r <= 1'b0;
    else if (timing_control_register_write_i)
      timing_control_register_r <= 1'b1;
  end

  // ==========================================================
  // mode sequencer
  always_comb
  begin
    st_nxt  = st_r;
    ext_nxt = ext_hold_r;
    unique case (st_r)
      ST_RESET:
      begin
        if (ext_hold_r)
        begin
          if (pin_s.rst_n)
            st_nxt = go_up;
        end
        else if (hold_done)
          st_nxt = pin_s.vdd_low ? ST_SLEEP : go_up;
      end
      ST_NREQ:
      begin
        if (pin_s.vdd_low)
          st_nxt = ST_RESET;
        else if (cmd_normal_i && timing_control_register_r)
          st_nxt = ST_NORMAL;
        else if (mode_done)
          st_nxt = ST_RESET;
      end
      ST_NORMAL:
      begin
        if (pin_s.vdd_low)
          st_nxt = pin_s.supply_undervoltage ? ST_RESET :
                   (vdd_done ? ST_SLEEP : ST_NORMAL);
        else if (vdd_back || wd_fail)
          st_nxt = ST_RESET;
        else if (cmd_sleep_i)
          st_nxt = ST_SLEEP;
        else if (cmd_stop_i)
          st_nxt = ST_STOP;
      end
      ST_STOP:
      begin
        if (pin_s.vdd_low)
          st_nxt = ST_RESET;
        else if (flag_wake || cs_wk)
          st_nxt = go_up;
      end
      ST_SLEEP:
      begin
        if (flag_wake)
          st_nxt = ST_RESET;
      end
    endcase
    if (ext_rst && !in_sleep && !in_reset)
    begin
      st_nxt  = ST_RESET;
      ext_nxt = 1'b1;
    end
    if (st_nxt != ST_RESET)
      ext_nxt = 1'b0;
  end

  assign drv_nxt = ((st_nxt == ST_RESET) && !ext_nxt) ||
                   ((st_nxt == ST_NORMAL) && pin_s.vdd_low);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_r        <= ST_RESET;
      ext_hold_r  <= 1'b0;
      rst_drive_r <= 1'b1;
      drv_hist_r  <= 4'hF;
    end
    else
    begin
      st_r        <= st_nxt;
      ext_hold_r  <= ext_nxt;
      rst_drive_r <= drv_nxt;
      drv_hist_r  <= {drv_hist_r[2:0], rst_drive_r};
    end
  end

  // ==========================================================
  // low power timing: cyclic sense and forced wake
  assign cyc       = wake_cfg_i.cyclic;
  assign forced_en = wake_cfg_i.forced && !cyc;
  assign lp_run    = in_lp && (cyc || wake_cfg_i.forced);
  assign tick      = lp_run && (lp_cnt_r == wake_cfg_i.period);
  assign lx_lvl    = {pin_s.wake_input_two, pin_s.wake_input_one};
  assign lx_chg    = {pin_chg.wake_input_two, pin_chg.wake_input_one};
  assign cs_chg    = (samp_vld_r && (on_cnt_r == 8'h01)) ? (lx_lvl ^ samp_r) : 2'h0;

  always_ff @(posedge clk_i)
  begin
    if (reset_i || !lp_run || tick)
      lp_cnt_r <= '0;
    else
      lp_cnt_r <= lp_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || !lp_run || !cyc)
    begin
      on_cnt_r   <= 8'h00;
      samp_r     <= 2'h0;
      samp_vld_r <= 1'b0;
    end
    else if (tick)
      on_cnt_r <= `SMWR_CS_ON_CYC;
    else if (on_cnt_r != 8'h00)
    begin
      on_cnt_r <= on_cnt_r - 8'h01;
      if (on_cnt_r == 8'h01)
      begin
        samp_r     <= lx_lvl;
        samp_vld_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // wake sources
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      mux_block_r <= 2'h0;
    else if ((st_nxt == ST_STOP || st_nxt == ST_SLEEP) && !in_lp)
      mux_block_r <= wake_cfg_i.mux_select;
  end

  assign lx_ok     = wake_cfg_i.wake_input_enable & ~mux_block_r;
  assign lx_wk     = in_lp ? (lx_ok & (cyc ? cs_chg : lx_chg)) : 2'h0;
  assign lin_wk    = in_lp && pin_chg.lin_wake && pin_s.lin_wake &&
                     !(in_stop && lin_receive_only_bit_i);
  assign forced_wk = in_lp && forced_en && tick;
  assign cs_wk     = in_stop && pin_chg.cs_n && pin_s.cs_n;
  assign flag_wake = (|lx_wk) || lin_wk || forced_wk;

  // ==========================================================
  // interrupt source flags and interrupt line
  assign flt_lvl = {pin_s.ls_overtemp, pin_s.hs_overtemp,
                    pin_s.lin_overtemp || pin_s.txd_stuck || pin_s.rxd_short,
                    pin_s.reg_overtemp, pin_s.supply_overvoltage, pin_s.supply_undervoltage};
  assign flt_evt = active ? (flt_lvl & ~flt_prev_r) : 6'h00;
  assign isr_set = {flt_evt, forced_wk, lin_wk, lx_wk};

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      isr_r      <= `SMWR_ISR_RST;
      flt_prev_r <= 6'h00;
    end
    else
    begin
      isr_r      <= (isr_read_i ? `SMWR_ISR_RST : isr_r) | isr_set;
      flt_prev_r <= flt_lvl;
    end
  end

  assign irq_block = in_sleep || !pin_s.rst_n || rst_drive_r;
  assign irq_set   = (in_stop && flag_wake) ||
                     ((|(flt_evt & irq_mask_i)) &&
                      (isr_r[`SMWR_ISR_WAKE_LSB +: `SMWR_ISR_WAKE_W] == 4'h0));

  always_ff @(posedge clk_i)
  begin
    if (reset_i || irq_block)
      irq_r <= 1'b0;
    else if (irq_set)
      irq_r <= 1'b1;
    else if (isr_read_i)
      irq_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      bat_r <= 1'b1;
    else if (isr_read_i)
      bat_r <= 1'b0;
  end

  // ==========================================================
  // lin driver fault lock
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      lin_lock_r <= 1'b0;
    else if (flt_lvl[3])
      lin_lock_r <= 1'b1;
    else if (pin_s.txd_recessive)
      lin_lock_r <= 1'b0;
  end

  // ==========================================================
  // gated outputs
  assign pwm_ok = !sw_cfg_i.pwm_gate || pin_s.pulse_width_input;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      high_side_switch_o  <= 1'b0;
      low_side_switches_o <= 2'h0;
      vdd_reg_en_o        <= 1'b1;
      mux_en_o            <= 1'b0;
      lin_drv_en_o        <= 1'b0;
      lin_rx_only_o       <= 1'b0;
      lp_osc_en_o         <= 1'b0;
      wd_active_o         <= 1'b0;
      wake_status_o       <= 2'h0;
    end
    else
    begin
      high_side_switch_o  <= (active && sw_cfg_i.high_side_switch && pwm_ok) ||
                             (in_lp && (on_cnt_r != 8'h00));
      low_side_switches_o <= (active && pwm_ok) ? sw_cfg_i.low_side_switches : 2'h0;
      vdd_reg_en_o        <= !in_sleep && !pin_s.reg_overtemp;
      mux_en_o            <= active;
      lin_drv_en_o        <= in_norm && !lin_receive_only_bit_i && !lin_lock_r;
      lin_rx_only_o       <= in_nr || in_stop || (in_norm && lin_receive_only_bit_i);
      lp_osc_en_o         <= lp_run;
      wd_active_o         <= in_nr || (in_norm && wd_res_r);
      wake_status_o       <= lx_lvl;
    end
  end

  assign mode_o              = st_r;
  assign rst_o               = 1'b0;
  assign rst_oe_o            = rst_drive_r;
  assign irq_n_o             = !irq_r;
  assign isr_o               = isr_r;
  assign battery_fail_flag_o = bat_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  stop_entry_a: assert property (in_stop && !$past(in_stop) |-> $past(cmd_stop_i))
    else $error("stop entered without stop command");
  sleep_cmd_a: assert property (in_norm && cmd_sleep_i && !pin_s.vdd_low && !vdd_back
    && !wd_fail && !ext_rst |=> st_r == ST_SLEEP)
    else $error("sleep command not obeyed");
  irq_ack_a: assert property (!irq_n_o && isr_read_i && !irq_set |=> irq_n_o)
    else $error("interrupt line not released on read");
  irq_quiet_a: assert property (in_sleep && $past(in_sleep) |-> irq_n_o)
    else $error("interrupt asserted in sleep");
  rst_hold_a: assert property ($fell(rst_oe_o) |-> $past(hold_done) || in_sleep)
    else $error("reset line released before hold time");
  wd_closed_a: assert property (in_norm && wd_res_r && wd_trigger_i && !mode_half
    && !pin_s.vdd_low |=> st_r == ST_RESET)
    else $error("closed window trigger not punished");
  nreq_to_a: assert property (in_nr && mode_done && !(cmd_normal_i && timing_control_register_r)
    |=> st_r == ST_RESET)
    else $error("normal request timeout missed");
  sw_off_a: assert property (in_reset && $past(in_reset)
    |-> !high_side_switch_o && low_side_switches_o == 2'h0)
    else $error("switch on in reset mode");
  lin_lock_a: assert property (lin_lock_r |=> !lin_drv_en_o)
    else $error("lin driver on while locked");
  sleep_wake_a: assert property (in_sleep && flag_wake && pin_s.rst_n
    |=> in_reset ##1 isr_o[`SMWR_ISR_WAKE_LSB +: `SMWR_ISR_WAKE_W] != 4'h0)
    else $error("sleep wake not routed through reset");
endmodule
`default_nettype wire

// >>> sim/smwr_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// host model: boots the device and acknowledges interrupts
module smwr_host
  import smwr_pkg::*;
(
  // clock and enable
  input  wire logic       clk_i,
  input  wire logic       en_i,
  // device side
  input  wire smwr_mode_e mode_i,
  input  wire logic       irq_n_i,
  // decoded spi accesses
  output logic            timing_control_register_write_o,
  output logic            cmd_normal_o,
  output logic            isr_read_o
);
  int low_cnt;
  initial
  begin
    timing_control_register_write_o = 1'b0;
    cmd_normal_o  = 1'b0;
    isr_read_o    = 1'b0;
    low_cnt       = 0;
    forever
    begin
      @(negedge clk_i);
      cmd_normal_o  = timing_control_register_write_o;
      timing_control_register_write_o = en_i && mode_i == ST_NREQ && !cmd_normal_o;
      isr_read_o    = en_i && low_cnt == 8;
      low_cnt       = irq_n_i ? 0 : low_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import smwr_pkg::*;
;
  logic           clk_i, reset_i, c_sleep, c_stop, h_en;
  logic           t_wr, c_norm, i_rd, rst_oe, irq_n, bf, vdd_en;
  logic [9:0]     interrupt_source_register;
  logic [5:0]     mask;
  logic           rxo, trig, hs, mux, ldrv, lrx, lpo, wda, rsto;
  logic [1:0]     ls, ws;
  logic [9:0]     eo;
  int             seed, failures, compares;
  smwr_pins_s     pins;
  smwr_wake_cfg_s wcfg;
  smwr_sw_cfg_s   swc;
  smwr_mode_e     mode, last, expq[$];
  // ==========================================================
  // device and host
  smwr_mode_ctrl #(.RST_HOLD_CYC(20), .NREQ_TO_CYC(200), .VDD_LOW_CYC(100),
    .WD_WIN_CYC(100)) i_smwr_mode_ctrl (
    .clk_i(clk_i), .reset_i(reset_i), .pins_i(pins),
    .cmd_sleep_i(c_sleep), .cmd_stop_i(c_stop), .cmd_normal_i(c_norm),
    .timing_control_register_write_i(t_wr), .wd_trigger_i(trig), .isr_read_i(i_rd),
    .lin_receive_only_bit_i(rxo), .irq_mask_i(mask),
    .wake_cfg_i(wcfg), .sw_cfg_i(swc), .mode_o(mode), .rst_o(rsto),
    .rst_oe_o(rst_oe), .irq_n_o(irq_n), .vdd_reg_en_o(vdd_en),
    .high_side_switch_o(hs), .low_side_switches_o(ls), .mux_en_o(mux),
    .lin_drv_en_o(ldrv), .lin_rx_only_o(lrx), .lp_osc_en_o(lpo), .wd_active_o(wda),
    .isr_o(interrupt_source_register), .wake_status_o(ws), .battery_fail_flag_o(bf));
  smwr_host i_smwr_host (
    .clk_i(clk_i), .en_i(h_en), .mode_i(mode), .irq_n_i(irq_n),
    .timing_control_register_write_o(t_wr), .cmd_normal_o(c_norm), .isr_read_o(i_rd));
  // reset line pulled up, low while the device drives it
  always @*
    pins.rst_n = !rst_oe;
  // ==========================================================
  // checks and control
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    failures += expq.size();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wt();
    repeat (2000) if (expq.size() != 0) @(negedge clk_i);
    failures += expq.size();
    expq.delete();
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  // mode monitor takes the oldest expected mode on every change
  always @(posedge clk_i)
  begin
    #1;
    if (!reset_i && mode !== last)
    begin
      last = mode;
      chk("mode", {5'h00, (expq.size() != 0) ? expq.pop_front() : smwr_mode_e'(5'h00)}, {5'h00, mode});
    end
  end
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    failures++;
    end_sim();
  end
  // ==========================================================
  // scenarios
  initial
  begin
    seed = 32'h859E8232;
    reset_i = 1'b1;
    {c_sleep, c_stop, h_en, rxo, trig} = '0;
    failures = 0;
    compares = 0;
    last = ST_RESET;
    pins.wake_input_one = 1'b0;
    {pins.wake_input_two, pins.lin_wake, pins.pulse_width_input} = '0;
    {pins.watchdog_config_pin_gnd, pins.watchdog_config_pin_res, pins.vdd_low} = '0;
    {pins.supply_undervoltage, pins.supply_overvoltage, pins.reg_overtemp} = '0;
    {pins.lin_overtemp, pins.txd_stuck, pins.rxd_short} = '0;
    {pins.hs_overtemp, pins.ls_overtemp} = '0;
    {pins.cs_n, pins.txd_recessive} = 2'h3;
    mask = $random(seed);
    mask[3] = 1'b1;
    swc = $random(seed);
    wcfg = '0;
    wcfg.wake_input_enable = 2'h3;
    wcfg.period = $random(seed);
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    chk("rst_oe", 10'h001, {9'h000, rst_oe});
    expq = '{ST_NREQ, ST_RESET, ST_NREQ};
    wt();
    chk("rst_oe", 10'h000, {9'h000, rst_oe});
    h_en = 1'b1;
    expq.push_back(ST_NORMAL);
    wt();
    @(negedge clk_i);
    eo = {!swc.pwm_gate && swc.high_side_switch, swc.pwm_gate ? 2'h0 : swc.low_side_switches, 7'h60};
    chk("outs", eo, {hs, ls, mux, ldrv, lrx, lpo, wda, ws});
    expq = '{ST_STOP, ST_NREQ, ST_NORMAL};
    pulse(c_stop);
    repeat (8) @(negedge clk_i);
    pins.cs_n = 1'b0;
    repeat (8) @(negedge clk_i);
    pins.cs_n = 1'b1;
    wt();
    chk("irq_n", 10'h001, {9'h000, irq_n});
    chk("isr", 10'h000, interrupt_source_register);
    expq = '{ST_STOP, ST_NREQ, ST_NORMAL};
    rxo = 1'b1;
    pulse(c_stop);
    pins.lin_wake = 1'b1;
    repeat (4) @(negedge clk_i);
    pins.lin_wake = 1'b0;
    repeat (8) @(negedge clk_i);
    chk("mode", {5'h00, ST_STOP}, {5'h00, mode});
    rxo = 1'b0;
    pins.lin_wake = 1'b1;
    repeat (4) @(negedge clk_i);
    pins.lin_wake = 1'b0;
    wt();
    chk("irq_n", 10'h000, {9'h000, irq_n});
    chk("isr", 10'h004, interrupt_source_register);
    repeat (12) @(negedge clk_i);
    chk("irq_n", 10'h001, {9'h000, irq_n});
    chk("isr", 10'h000, interrupt_source_register);
    pins.txd_stuck = 1'b1;
    repeat (6) @(negedge clk_i);
    chk("irq_n", 10'h000, {9'h000, irq_n});
    chk("isr", 10'h080, interrupt_source_register);
    chk("lin_drv", 10'h000, {9'h000, ldrv});
    pins.txd_stuck = 1'b0;
    repeat (12) @(negedge clk_i);
    chk("lin_drv", 10'h001, {9'h000, ldrv});
    chk("isr", 10'h000, interrupt_source_register);
    expq.push_back(ST_SLEEP);
    pulse(c_sleep);
    wt();
    @(negedge clk_i);
    chk("vdd_en", 10'h000, {8'h00, rsto, vdd_en});
    chk("outs", 10'h000, {hs, ls, mux, ldrv, lrx, lpo, wda, ws});
    expq = '{ST_RESET, ST_NREQ, ST_NORMAL};
    pins.watchdog_config_pin_res = 1'b1;
    pins.wake_input_one = 1'b1;
    wt();
    chk("isr", 10'h001, interrupt_source_register);
    chk("battery_fail_flag", 10'h000, {9'h000, bf});
    pins.supply_overvoltage = 1'b1;
    repeat (6) @(negedge clk_i);
    chk("irq_n", 10'h001, {9'h000, irq_n});
    chk("isr", 10'h021, interrupt_source_register);
    // open window trigger restarts, then overflow resets
    repeat (60) @(negedge clk_i);
    pulse(trig);
    repeat (60) @(negedge clk_i);
    chk("mode", {5'h00, ST_NORMAL}, {5'h00, mode});
    expq = '{ST_RESET, ST_NREQ, ST_NORMAL};
    wt();
    // closed window trigger resets
    expq = '{ST_RESET, ST_NREQ, ST_NORMAL};
    pulse(trig);
    wt();
    end_sim();
  end
endmodule
`default_nettype wire
